// ===== rtl/cpg_carrier.v
// Carrier generator: 8-bit timer making a carrier, gated by an envelope.
// Assumes an AHB-Lite master and an envelope interrupt from another domain.
//
// Functional notes
// - Low phase width from low compare, high phase width from high compare.
// - Mode 0 pin follows gate; mode 1 gate 1 passes carrier, else low.
// - Gate uses buffer (read/write) and active (read-only) bit pair.
// - Envelope interrupt is synchronised to count clock as sync event.
// - Buffer copied to active gate on second count clock after event rise.
// - Run enable starts counting; carrier stays low until first match.
// - First comparison after start uses the low compare value.
// - Low match: irq, invert carrier, clear counter, compare high next.
// - High match: irq, invert carrier, clear counter, compare low next.
// - Period is N+M+2 count clocks, M+1 of them high.
// - New high value transfers at old match, only after three clocks.
// - Gate rising starts pin carrier at next carrier rising edge.
// - Gate falling while carrier high keeps pin high to carrier fall.
// - Envelope interrupt is delivered at the synchronised event timing.
// - Clearing run enable stops counting.
// - Stopping returns compare irq and output pin to default low.
//
// The register offsets and register access over AHB-Lite were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
`include "cpg_consts.vh"

module cpg_carrier (
  // Clock and reset
  input wire hclk,
  input wire hresetn,
  // AHB-Lite slave
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire hready,
  input wire [31:0] hwdata,
  output reg [31:0] hrdata,
  output reg hreadyout,
  output reg hresp,
  // Envelope timer
  input wire envelope_timer_irq,
  output reg envelope_sync_event,
  // Timer outputs
  output reg compare_match_irq,
  output reg timer_output_pin
);

  // Software-visible state.
  reg run_enable_bit;
  reg remote_carrier_mode_bit;
  reg [2:0] count_clock_select;
  reg [7:0] low_width_compare;
  reg [7:0] high_width_compare;
  reg buffer_gate_bit;
  reg active_gate_bit;
  reg event_request;

  // Timer state.
  reg [7:0] prescale;
  reg [7:0] counter;
  reg [7:0] high_active;
  reg high_pending;
  reg [1:0] high_age;
  reg compare_high;
  reg carrier;
  reg gate_open;
  reg env_prev;
  reg transfer_arm;

  // Bus data-phase state.
  reg wr_pending;
  reg [`CPG_ADDR_W-1:0] wr_addr;

  wire env_level;
  wire [7:0] div_mask;
  wire count_tick;
  wire [7:0] compare_value;
  wire match;
  wire bus_take;
  wire [`CPG_ADDR_W-1:0] bus_addr;
  wire env_rise;
  reg [31:0] next_rdata;
  reg next_pin;

  cpg_sync u_env_sync (
    .hclk(hclk),
    .hresetn(hresetn),
    .async_in(envelope_timer_irq),
    .level(env_level)
  );

  // Count clock enable: hclk divided by 2 to the power of the select field.
  assign div_mask = ~(8'hff << count_clock_select);
  assign count_tick = ((prescale & div_mask) == div_mask);

  assign compare_value = compare_high ? high_active : low_width_compare;
  assign match = (counter == compare_value);
  assign env_rise = env_level & ~env_prev;

  assign bus_take = hsel & hready & (htrans == `CPG_HTRANS_NONSEQ ||
                                     htrans == `CPG_HTRANS_SEQ);
  assign bus_addr = haddr[`CPG_ADDR_W-1:0];

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      prescale <= 8'h00;
    end else begin
      prescale <= prescale + 8'h01;
    end
  end

  // Bus slave: zero wait states, always OKAY, writes land in the data phase.
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b0;
      hresp <= 1'b0;
      hrdata <= 32'h00000000;
      wr_pending <= 1'b0;
      wr_addr <= 5'h00;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      if (hready) begin
        wr_pending <= bus_take & hwrite;
        wr_addr <= bus_addr;
      end
      if (bus_take && !hwrite) begin
        hrdata <= next_rdata;
      end
    end
  end

  always @* begin
    next_rdata = 32'h00000000;
    if (bus_addr == `CPG_OFS_CTRL) begin
      next_rdata[`CPG_CTRL_RUN] = run_enable_bit;
      next_rdata[`CPG_CTRL_MODE] = remote_carrier_mode_bit;
      next_rdata[`CPG_CTRL_CKS_HI:`CPG_CTRL_CKS_LO] = count_clock_select;
    end else if (bus_addr == `CPG_OFS_LOW_CMP) begin
      next_rdata[7:0] = low_width_compare;
    end else if (bus_addr == `CPG_OFS_HIGH_CMP) begin
      next_rdata[7:0] = high_width_compare;
    end else if (bus_addr == `CPG_OFS_GATE) begin
      next_rdata[`CPG_GATE_BUF] = buffer_gate_bit;
      next_rdata[`CPG_GATE_ACT] = active_gate_bit;
    end else if (bus_addr == `CPG_OFS_STATUS) begin
      next_rdata[`CPG_ST_CNT_HI:`CPG_ST_CNT_LO] = counter;
      next_rdata[`CPG_ST_CARRIER] = carrier;
      next_rdata[`CPG_ST_SEL_HIGH] = compare_high;
      next_rdata[`CPG_ST_EVT_REQ] = event_request;
      next_rdata[`CPG_ST_HIGH_PEND] = high_pending;
    end
  end

  // Control, compare and gate registers written from the bus.
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      run_enable_bit <= 1'b0;
      remote_carrier_mode_bit <= 1'b0;
      count_clock_select <= 3'h0;
      low_width_compare <= `CPG_RST_CMP;
      high_width_compare <= `CPG_RST_CMP;
      buffer_gate_bit <= 1'b0;
    end else if (wr_pending) begin
      if (wr_addr == `CPG_OFS_CTRL) begin
        run_enable_bit <= hwdata[`CPG_CTRL_RUN];
        remote_carrier_mode_bit <= hwdata[`CPG_CTRL_MODE];
        count_clock_select <= hwdata[`CPG_CTRL_CKS_HI:`CPG_CTRL_CKS_LO];
      end else if (wr_addr == `CPG_OFS_LOW_CMP) begin
        low_width_compare <= hwdata[7:0];
      end else if (wr_addr == `CPG_OFS_HIGH_CMP) begin
        high_width_compare <= hwdata[7:0];
      end else if (wr_addr == `CPG_OFS_GATE) begin
        buffer_gate_bit <= hwdata[`CPG_GATE_BUF];
      end
    end
  end

  // Envelope event: sampled on count clocks, held for one count clock.
  // The request flag is write-one-to-clear; a new event beats the clear.
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      env_prev <= 1'b0;
      envelope_sync_event <= 1'b0;
      transfer_arm <= 1'b0;
      active_gate_bit <= 1'b0;
      event_request <= 1'b0;
    end else begin
      if (count_tick) begin
        env_prev <= env_level;
        envelope_sync_event <= env_rise;
        transfer_arm <= envelope_sync_event;
        if (transfer_arm) begin
          active_gate_bit <= buffer_gate_bit;
        end
      end
      if (count_tick && env_rise) begin
        event_request <= 1'b1;
      end else if (wr_pending && wr_addr == `CPG_OFS_STATUS &&
                   hwdata[`CPG_ST_EVT_REQ]) begin
        event_request <= 1'b0;
      end
    end
  end

  // Carrier timer. A stop clears everything back to the default levels.
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      counter <= 8'h00;
      compare_high <= 1'b0;
      carrier <= 1'b0;
      compare_match_irq <= 1'b0;
    end else if (!run_enable_bit) begin
      counter <= 8'h00;
      compare_high <= 1'b0;
      carrier <= 1'b0;
      compare_match_irq <= 1'b0;
    end else if (count_tick) begin
      compare_match_irq <= match;
      if (match) begin
        // Each phase lasts compare+1 ticks, giving N+M+2 in total.
        counter <= 8'h00;
        carrier <= ~carrier;
        compare_high <= ~compare_high;
      end else begin
        counter <= counter + 8'h01;
      end
    end
  end

  // High width shadow. A write is only eligible after three count clocks,
  // so a match that comes sooner keeps the old width for one more phase.
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      high_active <= `CPG_RST_CMP;
      high_pending <= 1'b0;
      high_age <= 2'h0;
    end else if (!run_enable_bit) begin
      high_active <= high_width_compare;
      high_pending <= 1'b0;
      high_age <= 2'h0;
    end else if (wr_pending && wr_addr == `CPG_OFS_HIGH_CMP) begin
      high_pending <= 1'b1;
      high_age <= 2'h0;
    end else if (count_tick && high_pending) begin
      if (match && compare_high && high_age == `CPG_HIGH_AGE) begin
        high_active <= high_width_compare;
        high_pending <= 1'b0;
      end else if (high_age != `CPG_HIGH_AGE) begin
        high_age <= high_age + 2'h1;
      end
    end
  end

  // When running, the gate only opens or closes while the carrier is low, so in mode 1 the pin
  // never starts mid-pulse and never cuts a high phase short.
  always @* begin
    next_pin = 1'b0;
    if (run_enable_bit) begin
      if (remote_carrier_mode_bit) begin
        next_pin = gate_open & carrier;
      end else begin
        next_pin = active_gate_bit;
      end
    end
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      gate_open <= 1'b0;
      timer_output_pin <= 1'b0;
    end else begin
      if (!run_enable_bit) begin
        gate_open <= 1'b0;
      end else if (!carrier) begin
        gate_open <= active_gate_bit;
      end
      timer_output_pin <= next_pin;
    end
  end

endmodule // cpg_carrier

`default_nettype wire

// ===== shared/cpg_consts.vh
// Constants for the carrier pulse generator: register map, fields, resets.
// Assumes a 32-bit AHB-Lite slave with one aligned word per register.
`ifndef CPG_CONSTS_VH
`define CPG_CONSTS_VH

// Register byte offsets (haddr[4:0]).
`define CPG_ADDR_W 5
`define CPG_OFS_CTRL 5'h00
`define CPG_OFS_LOW_CMP 5'h04
`define CPG_OFS_HIGH_CMP 5'h08
`define CPG_OFS_GATE 5'h0c
`define CPG_OFS_STATUS 5'h10

// Control register fields.
`define CPG_CTRL_RUN 0
`define CPG_CTRL_MODE 1
`define CPG_CTRL_CKS_LO 2
`define CPG_CTRL_CKS_HI 4

// Gate register fields.
`define CPG_GATE_BUF 0
`define CPG_GATE_ACT 1

// Status register fields.
`define CPG_ST_CNT_LO 0
`define CPG_ST_CNT_HI 7
`define CPG_ST_CARRIER 8
`define CPG_ST_SEL_HIGH 9
`define CPG_ST_EVT_REQ 10
`define CPG_ST_HIGH_PEND 11

// Reset values.
`define CPG_RST_CTRL 5'h00
`define CPG_RST_CMP 8'h01

// Count clocks a new high width must age before it may be transferred.
`define CPG_HIGH_AGE 2'h3

// AHB encodings.
`define CPG_HTRANS_NONSEQ 2'h2
`define CPG_HTRANS_SEQ 2'h3

`endif

// ===== rtl/cpg_sync.v
// Three-stage synchroniser for one asynchronous level input.
// Assumes the input may change at any time relative to hclk.
`timescale 1ns/100ps
`default_nettype none

module cpg_sync (
  // Clock and reset
  input wire hclk,
  input wire hresetn,
  // Asynchronous input and filtered level
  input wire async_in,
  output reg level
);

  reg stage1;
  reg stage2;
  reg stage3;

  // The level only moves once the second and third stages agree.
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      stage1 <= 1'b0;
      stage2 <= 1'b0;
      stage3 <= 1'b0;
      level <= 1'b0;
    end else begin
      stage1 <= async_in;
      stage2 <= stage1;
      stage3 <= stage2;
      if (stage2 == stage3) begin
        level <= stage3;
      end
    end
  end

endmodule // cpg_sync

`default_nettype wire

// ===== testbench/cpg_carrier_properties.sv
// Checker for the carrier generator, watching only its top ports.
// Assumes the low width stays fixed while the timer runs.
`timescale 1ns/100ps
`default_nettype none
`include "cpg_consts.vh"

module cpg_carrier_props (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Bus
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  // Envelope and timer outputs
  input wire logic envelope_timer_irq,
  input wire logic envelope_sync_event,
  input wire logic compare_match_irq,
  input wire logic timer_output_pin
);
  logic wr_p;
  logic [4:0] a_p;
  logic run_s;
  logic mode_s;
  logic [2:0] sel_s;
  logic [7:0] low_s;
  logic ph;
  logic full;
  logic irq_d;
  logic [11:0] gap;
  logic [11:0] exp_low;

  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);

  assign exp_low = ({4'h0, low_s} + 12'h001) << sel_s;

  // Control and low width are shadowed from bus writes.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_p <= 1'b0;
      a_p <= 5'h00;
      {sel_s, mode_s, run_s} <= 5'h00;
      low_s <= 8'h01;
      ph <= 1'b0;
      full <= 1'b0;
      irq_d <= 1'b0;
      gap <= 12'h000;
    end else begin
      if (hready) begin
        wr_p <= hsel && hwrite && htrans[1];
        a_p <= haddr[4:0];
      end
      if (hready && wr_p && a_p == `CPG_OFS_CTRL)
        {sel_s, mode_s, run_s} <= hwdata[4:0];
      if (hready && wr_p && a_p == `CPG_OFS_LOW_CMP)
        low_s <= hwdata[7:0];
      irq_d <= compare_match_irq;
      gap <= (compare_match_irq && !irq_d) ? 12'h001 : gap + 12'h001;
      // The first low phase after a start is skipped: its origin is fuzzy.
      if (!run_s) begin
        ph <= 1'b0;
        full <= 1'b0;
      end else if (compare_match_irq && !irq_d) begin
        ph <= !ph;
        full <= full | ph;
      end
    end
  end

  AST_BUS_READY: assert property ($past(hresetn) |-> hreadyout)
    else $error("hreadyout low after reset");
  AST_BUS_OKAY: assert property (!hresp)
    else $error("bus response not okay");
  AST_EVT_CAUSE: assert property (
    $rose(envelope_sync_event) |-> envelope_timer_irq)
    else $error("sync event without envelope interrupt");
  AST_EVT_TIMELY: assert property (
    run_s && $rose(envelope_timer_irq) |-> ##[1:16] $rose(envelope_sync_event))
    else $error("sync event late or missing");
  AST_EVT_ONCE: assert property (
    $rose(envelope_sync_event) |=> !$rose(envelope_sync_event) [*8])
    else $error("sync event repeated");
  AST_STOP_QUIET: assert property (
    !run_s |=> !timer_output_pin && !compare_match_irq)
    else $error("outputs active while stopped");
  AST_LOW_WIDTH: assert property (
    $rose(compare_match_irq) && !ph && full |-> gap == exp_low)
    else $error("low phase width wrong");
  AST_PIN_RISE: assert property (
    run_s && mode_s && $rose(timer_output_pin) |-> $past(compare_match_irq))
    else $error("pin rose mid carrier");
  AST_PIN_FALL: assert property (
    run_s && mode_s && $fell(timer_output_pin) |-> $past(compare_match_irq))
    else $error("pin fell mid high phase");

  COV_PIN: cover property ($rose(timer_output_pin));
  COV_EVT: cover property ($rose(envelope_sync_event));
  COV_STOP: cover property ($fell(run_s));
endmodule // cpg_carrier_props

bind cpg_carrier cpg_carrier_props i_props (.hclk, .hresetn, .hsel, .haddr,
  .htrans, .hwrite, .hsize, .hready, .hwdata, .hrdata, .hreadyout, .hresp,
  .envelope_timer_irq, .envelope_sync_event, .compare_match_irq,
  .timer_output_pin);
`default_nettype wire

// ===== testbench/cpg_env_model.sv
// Envelope timer model: one interrupt pulse per fire request.
// Assumes requests come only after the previous pulse has ended.
`timescale 1ns/100ps
`default_nettype none

module cpg_env_model (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Request and interrupt
  input wire logic fire,
  output logic envelope_timer_irq
);
  logic [4:0] len;

  // A long pulse stands for a slow envelope count clock.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      len <= 5'h00;
      envelope_timer_irq <= 1'b0;
    end else if (fire) begin
      len <= 5'h10;
      envelope_timer_irq <= 1'b1;
    end else if (len != 5'h00) begin
      len <= len - 5'h01;
    end else begin
      envelope_timer_irq <= 1'b0;
    end
  end
endmodule // cpg_env_model
`default_nettype wire

// ===== testbench/carrier_pulse_generator_bench.sv
// Directed bench for the carrier generator over AHB-Lite.
// Assumes hreadyout is fed back as hready; the checker is bound.
`timescale 1ns/100ps
`default_nettype none
`include "cpg_consts.vh"

module carrier_pulse_generator_bench;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic fire = 1'b0;
  wire [31:0] hrdata;
  wire hready;
  wire hresp;
  wire env_irq;
  wire cmp_irq;
  wire pin;
  int err_count = 0;
  int check_count = 0;
  int cyc = 0;
  int hi;
  int lo;
  logic [31:0] q;

  always #5 hclk = ~hclk;

  cpg_carrier i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hready(hready), .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hready),
    .hresp(hresp), .envelope_timer_irq(env_irq), .envelope_sync_event(),
    .compare_match_irq(cmp_irq), .timer_output_pin(pin));
  cpg_env_model i_env (.hclk(hclk), .hresetn(hresetn), .fire(fire),
    .envelope_timer_irq(env_irq));

  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= `CPG_HTRANS_NONSEQ;
    hwrite <= w;
    haddr <= {27'h0, a};
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    q = hrdata;
  endtask

  task automatic chk(input string nm, input logic [31:0] got,
                     input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic rdc(input logic [4:0] a, input logic [31:0] exp, string nm);
    bus(1'b0, a, 32'h0);
    chk(nm, q, exp);
  endtask

  // Waits for a fresh high phase so that partial pulses are not measured.
  task automatic meas();
    hi = 0;
    lo = 0;
    while (pin !== 1'b0) @(posedge hclk);
    while (pin !== 1'b1) @(posedge hclk);
    while (pin === 1'b1) begin
      hi++;
      @(posedge hclk);
    end
    while (pin === 1'b0) begin
      lo++;
      @(posedge hclk);
    end
  endtask

  task automatic evt(input logic v);
    bus(1'b1, `CPG_OFS_GATE, {31'h0, v});
    while (env_irq !== 1'b0) @(posedge hclk);
    repeat (8) @(posedge hclk);
    fire <= 1'b1;
    @(posedge hclk);
    fire <= 1'b0;
    q = 32'h0;
    repeat (40) if (q[10] !== 1'b1) bus(1'b0, `CPG_OFS_STATUS, 32'h0);
    chk("request flag", q[10], 1'b1);
    bus(1'b1, `CPG_OFS_STATUS, 32'h400);
    bus(1'b0, `CPG_OFS_GATE, 32'h0);
    repeat (20) if (q[1] !== v) bus(1'b0, `CPG_OFS_GATE, 32'h0);
    chk("active gate", q, {30'h0, v, v});
    bus(1'b0, `CPG_OFS_STATUS, 32'h0);
    chk("request cleared", q[10], 1'b0);
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  always @(posedge hclk) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      conclude();
    end
  end

  initial begin
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    rdc(`CPG_OFS_CTRL, 32'h0, "ctrl reset");
    rdc(`CPG_OFS_LOW_CMP, 32'h1, "low reset");
    rdc(`CPG_OFS_HIGH_CMP, 32'h1, "high reset");
    bus(1'b1, 5'h14, 32'hff);
    rdc(5'h14, 32'h0, "unmapped");
    bus(1'b1, `CPG_OFS_GATE, 32'h3);
    rdc(`CPG_OFS_GATE, 32'h1, "gate read only");
    $display("test registers done");
    bus(1'b1, `CPG_OFS_LOW_CMP, 32'h3);
    bus(1'b1, `CPG_OFS_HIGH_CMP, 32'h2);
    bus(1'b1, `CPG_OFS_CTRL, 32'h06);
    bus(1'b1, `CPG_OFS_CTRL, 32'h07);
    evt(1'b1);
    meas();
    chk("high width", hi, 32'd6);
    chk("low width", lo, 32'd8);
    bus(1'b1, `CPG_OFS_HIGH_CMP, 32'h5);
    // A write landing late in a high phase is too young for that phase's
    // high match, so the new width may only show two high phases later.
    meas();
    meas();
    meas();
    chk("new high width", hi, 32'd12);
    evt(1'b0);
    repeat (16) @(posedge hclk);
    chk("gated off", pin, 1'b0);
    $display("test carrier done");
    bus(1'b1, `CPG_OFS_CTRL, 32'h0);
    bus(1'b1, `CPG_OFS_HIGH_CMP, 32'h2);
    chk("pin stopped", pin, 1'b0);
    chk("irq stopped", cmp_irq, 1'b0);
    rdc(`CPG_OFS_STATUS, 32'h0, "stopped status");
    bus(1'b1, `CPG_OFS_CTRL, 32'h01);
    evt(1'b1);
    chk("level high", pin, 1'b1);
    evt(1'b0);
    chk("level low", pin, 1'b0);
    $display("test level mode done");
    conclude();
  end
endmodule // carrier_pulse_generator_bench
`default_nettype wire
